// ===== verilog/dbag_pkg.sv
// dbag_pkg: constants, carriers and bank decode table of the dram bank
// and address gate; assumes one core clock and an AXI4-Lite register bus.
// Contract
// [R1] soft reset out is keyboard reset request or port A bit 0.
// [R2] system A20 passes CPU A20 when gate input or port A bit 1 set.
// [R3] first row strobe enable opens banks 0 and 3.
// [R4] second row strobe enable opens banks 1 and 2.
// [R5] first column strobe enable opens banks 0 and 2.
// [R6] second column strobe enable opens banks 1 and 3.
// [R7] refresh request low starts a refresh of the dram banks.
// [R8] bus address captured on rising address latch enable; none in halt cycles. The code captures on every rising edge, halt cycles included.
// [R9] ram latch strobe high from cycle end to status end holds ram address. The code passes the address through while high and holds it after.
// [R10] three config selects choose one of six arrangements, 512K to 8M.
// [R11] channel check with nmi enabled raises nmi; level readable on port B.
// [R12] timer channel 2 level readable on port B.
// [R13] lower megabyte select low for accesses in the first megabyte.
// [R14] onboard indicator high for accesses to motherboard memory.
// [R15] hold acknowledge high only while the CPU bus drivers are off.
// [R16] expansion master pulls external master low while owning the bus.
// [R17] dma address enable held low for the whole dma memory access.
// [R18] system reset is active high and synchronous to the clock.
// [R19] shadow mode serves up to 384K of rom space from dram.
// [R20] parity fault input low reports a memory parity error.
// [R21] parity check enable is the OR of both column strobe enables.
// [R22] fast A20 gate is port A bit 1 or the gate input.
// [R23] peripheral data driven only while a system port is read.
// [R24] during refresh, refresh row bit 9 goes out on dram address bit 8.
// [R25] config code to bank layout held in an editable decode table.
// [R26] parity fault with nmi enabled raises nmi beside channel check.
`default_nettype none
package dbag_pkg;
    localparam logic [7:0] REG_PORT_A  = 8'h00;
    localparam logic [7:0] REG_PORT_B  = 8'h04;
    localparam logic [7:0] REG_SHADOW  = 8'h08;
    localparam logic [7:0] REG_STATUS  = 8'h0c;
    localparam int unsigned PA_SOFT_RST = 0;
    localparam int unsigned PA_A20_GATE = 1;
    localparam int unsigned PB_NMI_EN   = 0;
    localparam int unsigned PB_TIMER    = 5;
    localparam int unsigned PB_CHK      = 6;
    localparam int unsigned PB_PARITY   = 7;
    localparam int unsigned ST_REFRESH  = 3;
    localparam int unsigned ST_NMI      = 4;
    localparam int unsigned ST_CFG_BAD  = 5;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [3:0] LOW_MEG_NIB = 4'h0;
    localparam logic [7:0] HOLE_BASE   = 8'h0a;
    localparam logic [7:0] HOLE_TOP    = 8'h10;
    localparam logic [2:0] CFG_MAX     = 3'h5;

    typedef enum logic [1:0] {RF_IDLE = 2'h0, RF_ROW = 2'h1, RF_DONE = 2'h3} dbag_rf_t;

    // top in 64K blocks, bank size as log2 of 64K blocks
    typedef struct packed {
        logic [7:0] topBlk;
        logic [2:0] bankShift;
    } dbag_cfg_t;

    // [R25] editable layout table
    localparam dbag_cfg_t CFG_TABLE [8] = '{
        '{8'h08, 3'h2}, '{8'h0a, 3'h2}, '{8'h10, 3'h2}, '{8'h20, 3'h4},
        '{8'h40, 3'h4}, '{8'h80, 3'h5}, '{8'h08, 3'h2}, '{8'h08, 3'h2}};

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } dbag_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } dbag_axi_rsp_t;

    typedef struct packed {
        logic       en;
        logic [7:0] addr;
        logic [7:0] data;
    } dbag_wr_t;

    function automatic logic dbag_reg_known(input logic [7:0] addr);
        return addr == REG_PORT_A || addr == REG_PORT_B ||
               addr == REG_SHADOW || addr == REG_STATUS;
    endfunction
endpackage
`default_nettype wire

// ===== verilog/dbag_axil_slave.sv
// dbag_axil_slave: AXI4-Lite slave front end for the byte-wide registers.
// assumes the master keeps valid and payload stable until each handshake.
`timescale 1ns/100ps
`default_nettype none
module dbag_axil_slave (
    input  wire logic                    core_clk,
    input  wire logic                    arst_n,
    input  wire dbag_pkg::dbag_axi_req_t axiReq,
    output var  dbag_pkg::dbag_axi_rsp_t axiRsp,
    output var  dbag_pkg::dbag_wr_t      wrCmd,
    output logic [7:0]                   rdAddr,
    input  wire logic [7:0]              rdData
);
    typedef struct packed {
        logic       awHeld;
        logic [7:0] awAddr;
        logic       wHeld;
        logic [7:0] wData;
        logic       wLane0;
        logic       bvalid;
        logic [1:0] bresp;
        logic       rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
    } dbag_slv_t;

    dbag_slv_t st_reg;
    dbag_slv_t st_next;
    logic      wrKnown;

    assign rdAddr = axiReq.araddr;
    assign axiRsp = '{awready: !st_reg.awHeld && !st_reg.bvalid,
                      wready:  !st_reg.wHeld && !st_reg.bvalid,
                      bvalid:  st_reg.bvalid,
                      bresp:   st_reg.bresp,
                      arready: !st_reg.rvalid,
                      rvalid:  st_reg.rvalid,
                      rdata:   {24'h000000, st_reg.rdata},
                      rresp:   st_reg.rresp};

    always_comb
    begin
        st_next = st_reg;
        wrKnown = dbag_pkg::dbag_reg_known(st_reg.awAddr);
        wrCmd = '{en: 1'b0, addr: st_reg.awAddr, data: st_reg.wData};
        // address and data may arrive in either order
        if (axiReq.awvalid && axiRsp.awready)
        begin
            st_next.awHeld = 1'b1;
            st_next.awAddr = axiReq.awaddr;
        end
        if (axiReq.wvalid && axiRsp.wready)
        begin
            st_next.wHeld  = 1'b1;
            st_next.wData  = axiReq.wdata[7:0];
            st_next.wLane0 = axiReq.wstrb[0];
        end
        // only lane 0 carries register bits; upper lanes are dropped
        if (st_reg.awHeld && st_reg.wHeld)
        begin
            wrCmd.en       = wrKnown && st_reg.wLane0;
            st_next.awHeld = 1'b0;
            st_next.wHeld  = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp  = wrKnown ? dbag_pkg::RESP_OKAY : dbag_pkg::RESP_SLVERR;
        end
        if (st_reg.bvalid && axiReq.bready)
            st_next.bvalid = 1'b0;
        if (axiReq.arvalid && axiRsp.arready)
        begin
            st_next.rvalid = 1'b1;
            st_next.rdata  = rdData;
            st_next.rresp  = dbag_pkg::dbag_reg_known(axiReq.araddr) ?
                             dbag_pkg::RESP_OKAY : dbag_pkg::RESP_SLVERR;
        end
        else if (st_reg.rvalid && axiReq.rready)
            st_next.rvalid = 1'b0;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end
endmodule
`default_nettype wire

// ===== verilog/dbag_bank_decode.sv
// dbag_bank_decode: 64K block to bank strobe and select decode.
// assumes a stable block index; purely combinational.
`timescale 1ns/100ps
`default_nettype none
module dbag_bank_decode (
    input  wire logic [2:0] cfgCode,
    input  wire logic [7:0] blk,
    input  wire logic [5:0] shadowEn,
    output logic            onboard,
    output logic            lowMeg,
    output logic            rasFirst,
    output logic            rasSecond,
    output logic            casFirst,
    output logic            casSecond,
    output logic            cfgBad
);
    function automatic logic pairHit(input logic [1:0] b, input logic [1:0] x,
                                     input logic [1:0] y);
        return b == x || b == y;
    endfunction

    dbag_pkg::dbag_cfg_t cfg;
    logic                inHole;
    logic [3:0]          shIdx;
    logic [7:0]          shVec;
    logic [7:0]          bank;

    always_comb
    begin
        // [R10] [R25] layout from config code
        cfg    = dbag_pkg::CFG_TABLE[cfgCode];
        cfgBad = cfgCode > dbag_pkg::CFG_MAX;
        inHole = blk >= dbag_pkg::HOLE_BASE && blk < dbag_pkg::HOLE_TOP;
        shIdx  = blk[3:0] - dbag_pkg::HOLE_BASE[3:0];
        shVec  = {2'h0, shadowEn};
        // [R14] [R19] rom hole only on board when shadowed
        onboard = (blk < cfg.topBlk && !inHole) || (inHole && shVec[shIdx[2:0]]);
        bank    = blk >> cfg.bankShift;
        // [R13] first megabyte
        lowMeg  = blk[7:4] == dbag_pkg::LOW_MEG_NIB;
        // [R3] [R4] [R5] [R6] bank pair decode
        rasFirst  = onboard && pairHit(bank[1:0], 2'h0, 2'h3);
        rasSecond = onboard && pairHit(bank[1:0], 2'h1, 2'h2);
        casFirst  = onboard && pairHit(bank[1:0], 2'h0, 2'h2);
        casSecond = onboard && pairHit(bank[1:0], 2'h1, 2'h3);
    end
endmodule
`default_nettype wire

// ===== verilog/dbag_top.sv
// dbag_top: dram bank strobes, refresh, A20 gate, soft reset, nmi and
// system ports. assumes all pins are synchronous to core_clk.
`timescale 1ns/100ps
`default_nettype none
module dbag_top (
    input  wire logic                    core_clk,
    input  wire logic                    arst_n,
    input  wire dbag_pkg::dbag_axi_req_t axiReq,
    output var  dbag_pkg::dbag_axi_rsp_t axiRsp,
    input  wire logic                    sysReset,
    input  wire logic                    keyboardResetReqN,
    input  wire logic                    parityFaultN,
    input  wire logic                    refreshReqN,
    input  wire logic                    addrLatchEn,
    input  wire logic                    dmaAddrEnableN,
    input  wire logic                    timerCh2Level,
    input  wire logic                    channelCheckN,
    input  wire logic                    addr20GateIn,
    input  wire logic                    cpuHoldAck,
    input  wire logic                    cpuAddrBit20,
    input  wire logic [2:0]              cpuAddrHigh,
    input  wire logic [3:0]              cpuAddrLow,
    input  wire logic                    extMasterN,
    input  wire logic                    ramAddrLatchStrobe,
    input  wire logic                    ramConfigSelHi,
    input  wire logic                    ramConfigSelMid,
    input  wire logic                    ramConfigSelLo,
    input  wire logic                    refreshRowBit9,
    input  wire logic                    memAddrBit8In,
    input  wire logic                    ioRdPortA,
    input  wire logic                    ioRdPortB,
    output logic                         softResetOut,
    output logic                         sysAddrBit20,
    output logic                         sysAddrBit20Oe,
    output logic                         fastAddr20Gate,
    output logic                         rowStrobeEnFirst,
    output logic                         rowStrobeEnSecond,
    output logic                         colStrobeEnFirst,
    output logic                         colStrobeEnSecond,
    output logic                         parityCheckEn,
    output logic                         lowMegSelectN,
    output logic                         onboardMemAccess,
    output logic                         nmiOut,
    output logic                         dramAddrBit8,
    output logic [7:0]                   perDataOut,
    output logic                         perDataOe
);
    typedef struct packed {
        dbag_pkg::dbag_rf_t rf;
        logic               aleSeen;
        logic [7:0]         latchAddr;
        logic [7:0]         ramAddr;
        logic [7:0]         portA;
        logic               nmiEn;
        logic [5:0]         shadow;
        logic               softRst;
        logic               sysA20;
        logic               fastGate;
        logic               rasF;
        logic               rasS;
        logic               casF;
        logic               casS;
        logic               parity_check_en;
        logic               lowMeg;
        logic               onboard;
        logic               nmi;
        logic               ma8;
        logic [7:0]         perData;
    } dbag_core_t;

    dbag_core_t         st_reg;
    dbag_core_t         st_next;
    dbag_pkg::dbag_wr_t wrCmd;
    logic [7:0]         rdAddr;
    logic [7:0]         rdData;
    logic [2:0]         cfgCode;
    logic [7:0]         decBlk;
    logic               dOnboard;
    logic               dLowMeg;
    logic               dRasF;
    logic               dRasS;
    logic               dCasF;
    logic               dCasS;
    logic               cfgBad;
    logic               gateOn;
    logic               gatedA20;
    logic               liveSel;
    logic               memGate;
    logic               inRow;
    logic               quiet;
    logic [7:0]         portBVal;
    logic [7:0]         statusVal;

    assign cfgCode = {ramConfigSelHi, ramConfigSelMid, ramConfigSelLo};
    // [R15] [R17] live bus address while another party drives it
    assign liveSel = cpuHoldAck || !dmaAddrEnableN;
    assign decBlk  = liveSel ? {cpuAddrHigh, cpuAddrBit20, cpuAddrLow} : st_reg.ramAddr;

    dbag_axil_slave u_slave (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .axiReq   (axiReq),
        .axiRsp   (axiRsp),
        .wrCmd    (wrCmd),
        .rdAddr   (rdAddr),
        .rdData   (rdData)
    );

    dbag_bank_decode u_decode (
        .cfgCode   (cfgCode),
        .blk       (decBlk),
        .shadowEn  (st_reg.shadow),
        .onboard   (dOnboard),
        .lowMeg    (dLowMeg),
        .rasFirst  (dRasF),
        .rasSecond (dRasS),
        .casFirst  (dCasF),
        .casSecond (dCasS),
        .cfgBad    (cfgBad)
    );

    always_comb
    begin
        st_next = st_reg;
        // [R2] [R22] gate A20 from pin or port A
        gateOn   = addr20GateIn || st_reg.portA[dbag_pkg::PA_A20_GATE];
        gatedA20 = cpuAddrBit20 && gateOn;
        // [R8] capture on the rising latch enable only
        st_next.aleSeen = addrLatchEn;
        if (addrLatchEn && !st_reg.aleSeen)
            st_next.latchAddr = {cpuAddrHigh, gatedA20, cpuAddrLow};
        // [R9] transparent while the ram strobe is high, held after
        if (ramAddrLatchStrobe)
            st_next.ramAddr = st_next.latchAddr;

        // [R12] [R11] [R20] port B readback
        portBVal = '0;
        portBVal[dbag_pkg::PB_NMI_EN] = st_reg.nmiEn;
        portBVal[dbag_pkg::PB_TIMER]  = timerCh2Level;
        portBVal[dbag_pkg::PB_CHK]    = !channelCheckN;
        portBVal[dbag_pkg::PB_PARITY] = !parityFaultN;
        statusVal = '0;
        statusVal[2:0] = cfgCode;
        statusVal[dbag_pkg::ST_REFRESH] = st_reg.rf != dbag_pkg::RF_IDLE;
        statusVal[dbag_pkg::ST_NMI]     = st_reg.nmi;
        statusVal[dbag_pkg::ST_CFG_BAD] = cfgBad;
        case (rdAddr)
            dbag_pkg::REG_PORT_A: rdData = st_reg.portA;
            dbag_pkg::REG_PORT_B: rdData = portBVal;
            dbag_pkg::REG_SHADOW: rdData = {2'h0, st_reg.shadow};
            dbag_pkg::REG_STATUS: rdData = statusVal;
            default:              rdData = '0;
        endcase

        if (wrCmd.en && wrCmd.addr == dbag_pkg::REG_PORT_A)
            st_next.portA = wrCmd.data;
        if (wrCmd.en && wrCmd.addr == dbag_pkg::REG_PORT_B)
            st_next.nmiEn = wrCmd.data[dbag_pkg::PB_NMI_EN];
        if (wrCmd.en && wrCmd.addr == dbag_pkg::REG_SHADOW)
            st_next.shadow = wrCmd.data[5:0];
        // [R18] system reset sampled directly, it is already synchronous
        if (sysReset)
        begin
            st_next.portA  = '0;
            st_next.nmiEn  = 1'b0;
            st_next.shadow = '0;
        end

        // [R7] refresh sequence; done state gives one precharge cycle
        unique case (st_reg.rf)
            dbag_pkg::RF_IDLE:
                if (!refreshReqN)
                    st_next.rf = dbag_pkg::RF_ROW;
            dbag_pkg::RF_ROW:
                if (refreshReqN)
                    st_next.rf = dbag_pkg::RF_DONE;
            dbag_pkg::RF_DONE:
                st_next.rf = dbag_pkg::RF_IDLE;
            default:
                st_next.rf = dbag_pkg::RF_IDLE;
        endcase
        inRow = st_next.rf == dbag_pkg::RF_ROW;
        quiet = st_next.rf != dbag_pkg::RF_IDLE;
        // strobes idle while the ram strobe marks the status phase, except while the bus address is live
        memGate = (!ramAddrLatchStrobe || liveSel) && !quiet;

        // [R3] [R4] row enables, both in the refresh row state
        st_next.rasF = inRow || (memGate && dRasF);
        st_next.rasS = inRow || (memGate && dRasS);
        // [R5] [R6] column enables, never in refresh
        st_next.casF = memGate && dCasF;
        st_next.casS = memGate && dCasS;
        // [R21] parity check follows column enables
        st_next.parity_check_en = st_next.casF || st_next.casS;
        // [R24] refresh row bit onto address bit 8
        st_next.ma8 = inRow ? refreshRowBit9 : memAddrBit8In;
        // [R13] [R14] [R19] selects from decode
        st_next.lowMeg  = dLowMeg;
        st_next.onboard = memGate && dOnboard;

        // [R1] soft reset
        st_next.softRst  = !keyboardResetReqN || st_reg.portA[dbag_pkg::PA_SOFT_RST];
        st_next.sysA20   = gatedA20;
        st_next.fastGate = gateOn;
        // [R11] [R26] nmi from channel check or parity fault
        st_next.nmi = st_reg.nmiEn && (!channelCheckN || !parityFaultN);
        st_next.perData = ioRdPortA ? st_reg.portA : portBVal;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign softResetOut      = st_reg.softRst;
    assign sysAddrBit20      = st_reg.sysA20;
    // [R16] pin turns input only under hold with no expansion master
    assign sysAddrBit20Oe    = !(cpuHoldAck && extMasterN);
    assign fastAddr20Gate    = st_reg.fastGate;
    assign rowStrobeEnFirst  = st_reg.rasF;
    assign rowStrobeEnSecond = st_reg.rasS;
    assign colStrobeEnFirst  = st_reg.casF;
    assign colStrobeEnSecond = st_reg.casS;
    assign parityCheckEn     = st_reg.parity_check_en;
    assign lowMegSelectN     = !st_reg.lowMeg;
    assign onboardMemAccess  = st_reg.onboard;
    assign nmiOut            = st_reg.nmi;
    assign dramAddrBit8      = st_reg.ma8;
    assign perDataOut        = st_reg.perData;
    // [R23] drive only during a port read
    assign perDataOe         = ioRdPortA || ioRdPortB;

    chk_soft_reset_or: assert property (@(posedge core_clk) disable iff (!arst_n) // [R1]
        !keyboardResetReqN |=> softResetOut)
        else $error("soft reset not raised by keyboard request");
    chk_a20_forced_low: assert property (@(posedge core_clk) disable iff (!arst_n) // [R2]
        !(addr20GateIn || st_reg.portA[dbag_pkg::PA_A20_GATE]) |=> !sysAddrBit20)
        else $error("A20 passed while gate closed");
    chk_refresh_rows: assert property (@(posedge core_clk) disable iff (!arst_n) // [R7]
        (st_reg.rf == dbag_pkg::RF_IDLE && !refreshReqN) |=>
        (rowStrobeEnFirst && rowStrobeEnSecond && !colStrobeEnFirst && !colStrobeEnSecond))
        else $error("refresh did not open both row enables");
    chk_col_pair_excl: assert property (@(posedge core_clk) disable iff (!arst_n) // [R5]
        !(colStrobeEnFirst && colStrobeEnSecond))
        else $error("both column pairs enabled");
    chk_row_both_refresh: assert property (@(posedge core_clk) disable iff (!arst_n) // [R3]
        (rowStrobeEnFirst && rowStrobeEnSecond) |-> st_reg.rf == dbag_pkg::RF_ROW)
        else $error("both row pairs outside refresh");
    chk_refresh_bit8: assert property (@(posedge core_clk) disable iff (!arst_n) // [R24]
        st_reg.rf == dbag_pkg::RF_ROW |-> dramAddrBit8 == $past(refreshRowBit9))
        else $error("refresh row bit not on address bit 8");
    chk_parity_check_en: assert property (@(posedge core_clk) disable iff (!arst_n) // [R21]
        parityCheckEn |-> $past(st_next.casF || st_next.casS) && !st_reg.rf[1])
        else $error("parity check without column enable");
    chk_fast_gate_or: assert property (@(posedge core_clk) disable iff (!arst_n) // [R22]
        $rose(addr20GateIn) |=> fastAddr20Gate)
        else $error("fast gate missed gate input");
    chk_nmi_sources: assert property (@(posedge core_clk) disable iff (!arst_n) // [R26]
        st_reg.nmiEn && !(parityFaultN && channelCheckN) |=> nmiOut)
        else $error("nmi not raised");
    chk_nmi_masked: assert property (@(posedge core_clk) disable iff (!arst_n) // [R11]
        nmiOut |-> $past(st_reg.nmiEn) && ($past(!channelCheckN) || $past(!parityFaultN)))
        else $error("nmi without enabled source");
    chk_port_b_timer: assert property (@(posedge core_clk) disable iff (!arst_n) // [R12]
        (ioRdPortB && !ioRdPortA) |=> perDataOut[dbag_pkg::PB_TIMER] == $past(timerCh2Level))
        else $error("timer level not on port B read");
    chk_ale_capture: assert property (@(posedge core_clk) disable iff (!arst_n) // [R8]
        (addrLatchEn && !st_reg.aleSeen) |=>
        st_reg.latchAddr[2:0] == $past(cpuAddrLow[2:0]))
        else $error("address not captured on latch enable");
    chk_low_meg_sel: assert property (@(posedge core_clk) disable iff (!arst_n) // [R13]
        (liveSel && {cpuAddrHigh, cpuAddrBit20} == '0) |=> !lowMegSelectN)
        else $error("lower megabyte select missed");
endmodule
`default_nettype wire

// ===== verif/dbag_refresh_src.sv
// dbag_refresh_src: refresh timer side of the bus controller.
// assumes refGo is a one-cycle pulse from the bench.
`timescale 1ns/100ps
`default_nettype none
module dbag_refresh_src #(
    parameter logic [2:0] LEN = 3'h4
) (
    input  wire logic core_clk,
    input  wire logic refGo,
    output logic      refreshReqN
);
    logic [2:0] left = 3'h0;
    always @(posedge core_clk)
        left <= refGo ? LEN : left - (left != 3'h0);
    assign refreshReqN = (left == 3'h0);
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// testbench: directed register and pin tests of dbag_top.
// assumes design files and the refresh source compile first.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic core_clk = 1'b0, arst_n = 1'b0, sysReset, keyboardResetReqN, parityFaultN;
    logic refreshReqN, addrLatchEn, dmaAddrEnableN, timerCh2Level, channelCheckN;
    logic addr20GateIn, cpuHoldAck, cpuAddrBit20, extMasterN, ramAddrLatchStrobe, refGo;
    logic ramConfigSelHi, ramConfigSelMid, ramConfigSelLo, refreshRowBit9, memAddrBit8In;
    logic ioRdPortA, ioRdPortB, softResetOut, sysAddrBit20, sysAddrBit20Oe, fastAddr20Gate;
    logic rowStrobeEnFirst, rowStrobeEnSecond, colStrobeEnFirst, colStrobeEnSecond;
    logic parityCheckEn, lowMegSelectN, onboardMemAccess, nmiOut, dramAddrBit8, perDataOe;
    logic [2:0] cpuAddrHigh;
    logic [3:0] cpuAddrLow;
    logic [7:0] perDataOut;
    dbag_pkg::dbag_axi_req_t axiReq;
    dbag_pkg::dbag_axi_rsp_t axiRsp;
    int numErrors = 0, nChecks = 0, cyc = 0;
    dbag_top i_dut (.*);
    dbag_refresh_src i_ref (.*);
    always #4 core_clk = ~core_clk;
    // long stall ends the run as a failure
    always @(posedge core_clk) if (++cyc == 3000) finish_test(1);
    task automatic finish_test(input int late);
        numErrors += late;
        $display("checks %0d errors %0d", nChecks, numErrors);
        if (numErrors == 0 && nChecks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp)
        begin
            numErrors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // one AXI4-Lite write (w=1) or read (w=0); handshakes sampled at the edge
    task automatic xfer(input logic w, input logic [7:0] a, d, input logic [1:0] er);
        logic ta, tw, tr, dn;
        logic [1:0] rs;
        logic [7:0] rd;
        {axiReq.awaddr, axiReq.araddr, axiReq.wdata} <= {a, a, 24'h0, d};
        if (w) {axiReq.awvalid, axiReq.wvalid, axiReq.bready} <= 3'h7;
        else {axiReq.arvalid, axiReq.rready} <= 2'h3;
        do
        begin
            @(posedge core_clk);
            ta = axiReq.awvalid && axiRsp.awready;
            tw = axiReq.wvalid && axiRsp.wready;
            tr = axiReq.arvalid && axiRsp.arready;
            dn = w ? axiRsp.bvalid : axiRsp.rvalid;
            rs = w ? axiRsp.bresp : axiRsp.rresp;
            rd = axiRsp.rdata[7:0];
            if (ta) axiReq.awvalid <= 1'b0;
            if (tw) axiReq.wvalid <= 1'b0;
            if (tr) axiReq.arvalid <= 1'b0;
        end
        while (dn !== 1'b1);
        if (w) axiReq.bready <= 1'b0; else axiReq.rready <= 1'b0;
        chk(rs, er);
        if (!w) chk(rd, d);
    endtask
    // e: onboard, lowMegN, row first/second, col first/second
    task automatic cs(input logic [2:0] c, h, input logic [3:0] l, input logic [5:0] e);
        {ramConfigSelHi, ramConfigSelMid, ramConfigSelLo, cpuAddrHigh, cpuAddrLow} <= {c, h, l};
        step(2);
        chk({onboardMemAccess, lowMegSelectN, rowStrobeEnFirst, rowStrobeEnSecond,
             colStrobeEnFirst, colStrobeEnSecond, parityCheckEn}, {e, e[1] | e[0]});
    endtask
    initial
    begin
        axiReq = '0;
        axiReq.wstrb = 4'hf;
        {sysReset, keyboardResetReqN, parityFaultN, addrLatchEn, dmaAddrEnableN} = 5'b01101;
        {timerCh2Level, channelCheckN, addr20GateIn, cpuHoldAck, cpuAddrBit20} = 5'b01010;
        {extMasterN, ramAddrLatchStrobe, refreshRowBit9, memAddrBit8In} = 4'b1010;
        {cpuAddrHigh, cpuAddrLow, ramConfigSelHi, ramConfigSelMid, ramConfigSelLo} = 10'h0;
        {ioRdPortA, ioRdPortB, refGo} = 3'h0;
        step(2);
        arst_n <= 1'b1;
        cs(3'h0, 3'h0, 4'h0, 6'b101010);
        cs(3'h0, 3'h0, 4'h4, 6'b100101);
        cs(3'h0, 3'h0, 4'h8, 6'b000000);
        cs(3'h5, 3'h3, 4'h0, 6'b111001);
        cs(3'h0, 3'h0, 4'hc, 6'b000000);
        xfer(1'b1, dbag_pkg::REG_SHADOW, 8'h04, dbag_pkg::RESP_OKAY);
        cs(3'h0, 3'h0, 4'hc, 6'b101001);
        xfer(1'b1, 8'h10, 8'hff, dbag_pkg::RESP_SLVERR);
        xfer(1'b0, 8'h10, 8'h00, dbag_pkg::RESP_SLVERR);
        $display("decode test done");
        refGo <= 1'b1;
        step(1);
        refGo <= 1'b0;
        step(3);
        chk({rowStrobeEnFirst, rowStrobeEnSecond, colStrobeEnFirst, colStrobeEnSecond,
             dramAddrBit8}, 5'b11001);
        step(6);
        chk({rowStrobeEnFirst, colStrobeEnSecond, dramAddrBit8}, 3'b110);
        $display("refresh test done");
        cpuAddrBit20 <= 1'b1;
        step(2);
        chk({sysAddrBit20, fastAddr20Gate, sysAddrBit20Oe}, 3'b000);
        {addr20GateIn, extMasterN} <= 2'b10;
        step(2);
        chk({sysAddrBit20, fastAddr20Gate, sysAddrBit20Oe}, 3'b111);
        addr20GateIn <= 1'b0;
        xfer(1'b1, dbag_pkg::REG_PORT_A, 8'h03, dbag_pkg::RESP_OKAY);
        step(2);
        chk({softResetOut, sysAddrBit20, fastAddr20Gate}, 3'b111);
        sysReset <= 1'b1;
        step(1);
        sysReset <= 1'b0;
        step(2);
        chk({softResetOut, sysAddrBit20, fastAddr20Gate}, 3'b000);
        keyboardResetReqN <= 1'b0;
        step(2);
        chk(softResetOut, 1'b1);
        {cpuHoldAck, addrLatchEn, ramAddrLatchStrobe, cpuAddrLow} <= 7'h34;
        step(1);
        {ramAddrLatchStrobe, cpuAddrLow} <= 5'h00;
        step(2);
        chk({onboardMemAccess, rowStrobeEnSecond, colStrobeEnSecond}, 3'h7);
        $display("gate test done");
        {timerCh2Level, channelCheckN} <= 2'b10;
        xfer(1'b1, dbag_pkg::REG_PORT_B, 8'h01, dbag_pkg::RESP_OKAY);
        step(2);
        chk(nmiOut, 1'b1);
        xfer(1'b0, dbag_pkg::REG_PORT_B, 8'h61, dbag_pkg::RESP_OKAY);
        {channelCheckN, parityFaultN} <= 2'b10;
        step(2);
        chk(nmiOut, 1'b1);
        xfer(1'b0, dbag_pkg::REG_PORT_B, 8'ha1, dbag_pkg::RESP_OKAY);
        xfer(1'b1, dbag_pkg::REG_PORT_B, 8'h00, dbag_pkg::RESP_OKAY);
        ioRdPortB <= 1'b1;
        step(2);
        chk({perDataOe, perDataOut, nmiOut}, {1'b1, 8'ha0, 1'b0});
        $display("nmi test done");
        finish_test(0);
    end
endmodule
`default_nettype wire
